// ### logic/rtcc_top.sv
// Real-time clock control, clock source selection and one-second flag
// Behaviour
// - Run bit 7 of control one stops the clock at 0, runs it at 1.
// - Soft-reset bit 4 resets clock logic except source register and itself.
// - Control two bit 2 enables the one-second interrupt.
// - Output select bits 6..4 choose pin clock; xx1 selects the subclock.
// - Source codes 0..7 free-running counter, 8 clock mode, 9..15 prohibited.
// - Source register bit 7 is reserved; writes never change it.
// - A one-second event sets flag bit 2 of the flag register.
// - The flag clears by writing 0 while it reads 1, or by soft reset.
// - Writing 1 to the flag does nothing.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rtcc_top #(
    parameter int unsigned SUB_TICKS_PER_SEC = rtcc_pkg::SUB_TICKS_DEFAULT
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    input  wire rtcc_pkg::rtcc_bus_s bus_req,
    output logic [7:0]         rd_data,
    input  wire logic          sub_clk,
    output logic               clock_output_pin,
    output logic               clock_output_oe,
    output logic               second_irq_req,
    output logic               irq
);
    import rtcc_pkg::*;

    function automatic logic hit(input logic [23:0] a, input logic [23:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic            run_reg;
    logic            srst_reg;
    logic            second_irq_enable_reg;
    logic [2:0]      out_sel_reg;
    logic [3:0]      src_sel_reg;
    logic            second_event_flag_reg;
    logic            port_mode_three_reg;
    logic [EV_W-1:0] ev_status_reg;
    logic [EV_W-1:0] ev_enable_reg;
    logic [7:0]      frc_reg;
    logic            sub_q_reg;
    logic [7:0]      rd_data_reg;
    logic            irq_reg;
    logic            second_irq_reg;

    logic            run_next;
    logic            srst_next;
    logic            second_irq_enable_next;
    logic [2:0]      out_sel_next;
    logic [3:0]      src_sel_next;
    logic            second_event_flag_next;
    logic            port_mode_three_next;
    logic [EV_W-1:0] ev_status_next;
    logic [EV_W-1:0] ev_enable_next;
    logic [7:0]      frc_next;
    logic [7:0]      rd_mux;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic wr_ccr1  = bus_req.wr && hit(bus_req.addr, ADDR_CCR1);
    wire logic wr_ccr2  = bus_req.wr && hit(bus_req.addr, ADDR_CCR2);
    wire logic wr_flg   = bus_req.wr && hit(bus_req.addr, ADDR_FLG);
    wire logic wr_csr   = bus_req.wr && hit(bus_req.addr, ADDR_CSR);
    wire logic wr_evclr = bus_req.wr && hit(bus_req.addr, ADDR_EV_CLR);
    wire logic wr_even  = bus_req.wr && hit(bus_req.addr, ADDR_EV_EN);
    wire logic wr_pmode = bus_req.wr && hit(bus_req.addr, ADDR_PORT_MODE);

    wire logic [3:0] wr_src   = bus_req.wdata[CSR_SRC_LSB +: 4];
    wire logic       src_prohib = wr_src > SRC_RTC;

    // ------------------------------------------------------------
    // Clock logic control
    // ------------------------------------------------------------
    // Held in reset while the bit stands, released in the same cycle
    // that software writes it back to 0 so a run write is not lost
    wire logic soft_rst = srst_reg && !(wr_ccr1 && !bus_req.wdata[BIT_SRST]);
    wire logic rtc_mode = src_sel_reg == SRC_RTC;
    wire logic frc_mode = !src_sel_reg[3];
    wire logic sub_rise = sub_clk && !sub_q_reg;
    wire logic presc_en = run_reg && rtc_mode;
    wire logic frc_en   = run_reg && frc_mode && sub_rise;
    wire logic frc_ovf  = frc_en && (frc_reg == FRC_MAX) && !soft_rst;
    wire logic sec_tick;

    rtcc_presc #(
        .TICKS (SUB_TICKS_PER_SEC)
    ) u_presc (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .clr       (soft_rst),
        .en        (presc_en),
        .tick      (sub_rise),
        .sec_pulse (sec_tick)
    );

    rtcc_pin_s clk_pin;

    rtcc_clkout u_clkout (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .sel       (out_sel_reg),
        .sub_level (sub_clk),
        .en        (port_mode_three_reg),
        .pin       (clk_pin)
    );

    wire logic sec_ev = sec_tick && !soft_rst;
    wire logic flg_clr = wr_flg && !bus_req.wdata[BIT_SEC_FLG] && second_event_flag_reg;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    assign run_next = wr_ccr1 ? bus_req.wdata[BIT_RUN] && !bus_req.wdata[BIT_SRST]
                    : (soft_rst ? RUN_RST : run_reg);
    assign srst_next = wr_ccr1 ? bus_req.wdata[BIT_SRST] : srst_reg;
    assign second_irq_enable_next = soft_rst ? 1'b0
                    : (wr_ccr2 ? bus_req.wdata[BIT_SEC_IE] : second_irq_enable_reg);
    assign out_sel_next = wr_csr ? bus_req.wdata[CSR_OUT_LSB +: 3] : out_sel_reg;
    // A prohibited code leaves the previous source in place
    assign src_sel_next = (wr_csr && !src_prohib) ? wr_src : src_sel_reg;
    // Set wins over a clear in the same cycle
    assign second_event_flag_next = soft_rst ? 1'b0
                    : (sec_ev ? 1'b1 : (flg_clr ? 1'b0 : second_event_flag_reg));
    assign port_mode_three_next = wr_pmode ? bus_req.wdata[BIT_PORT_MODE] : port_mode_three_reg;
    assign frc_next = soft_rst ? FRC_RST : (frc_en ? frc_reg + 8'h01 : frc_reg);
    assign ev_enable_next = wr_even ? bus_req.wdata[EV_W-1:0] : ev_enable_reg;
    assign ev_status_next = (ev_status_reg & ~(wr_evclr ? bus_req.wdata[EV_W-1:0] : '0))
                          | {frc_ovf, sec_ev};

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    assign rd_mux =
        hit(bus_req.addr, ADDR_CCR1)      ? {run_reg, 2'h0, srst_reg, 4'h0} :
        hit(bus_req.addr, ADDR_CCR2)      ? {5'h00, second_irq_enable_reg, 2'h0} :
        hit(bus_req.addr, ADDR_FLG)       ? {5'h00, second_event_flag_reg, 2'h0} :
        hit(bus_req.addr, ADDR_CSR)       ? {1'b0, out_sel_reg, src_sel_reg} :
        hit(bus_req.addr, ADDR_EV_STAT)   ? {6'h00, ev_status_reg} :
        hit(bus_req.addr, ADDR_EV_EN)     ? {6'h00, ev_enable_reg} :
        hit(bus_req.addr, ADDR_PORT_MODE) ? {7'h00, port_mode_three_reg} :
        hit(bus_req.addr, ADDR_FRC)       ? frc_reg : 8'h00;

    assign rd_data          = rd_data_reg;
    assign irq              = irq_reg;
    assign second_irq_req   = second_irq_reg;
    assign clock_output_pin = clk_pin.pin;
    assign clock_output_oe  = clk_pin.oe;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // One register to a process keeps each reset value beside its update
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_reg <= RUN_RST;
        end else begin
            run_reg <= run_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            srst_reg <= 1'b0;
        end else begin
            srst_reg <= srst_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_irq_enable_reg <= 1'b0;
        end else begin
            second_irq_enable_reg <= second_irq_enable_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_sel_reg <= OUT_SEL_RST;
        end else begin
            out_sel_reg <= out_sel_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            src_sel_reg <= SRC_SEL_RST;
        end else begin
            src_sel_reg <= src_sel_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_event_flag_reg <= 1'b0;
        end else begin
            second_event_flag_reg <= second_event_flag_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_mode_three_reg <= 1'b0;
        end else begin
            port_mode_three_reg <= port_mode_three_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            frc_reg <= FRC_RST;
        end else begin
            frc_reg <= frc_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sub_q_reg <= 1'b0;
        end else begin
            sub_q_reg <= sub_clk;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_status_reg <= '0;
        end else begin
            ev_status_reg <= ev_status_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_enable_reg <= EV_EN_RST;
        end else begin
            ev_enable_reg <= ev_enable_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(ev_status_reg & ev_enable_reg);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_irq_reg <= 1'b0;
        end else begin
            second_irq_reg <= second_event_flag_reg && second_irq_enable_reg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    stop_holds_a: assert property (!run_reg && !soft_rst |=> $stable(frc_reg))
        else $error("free-running counter moved while stopped");

    tick_cause_a: assert property (sec_tick |-> $past(presc_en) && $past(sub_rise))
        else $error("second event without running clock mode and subclock edge");

    soft_rst_a: assert property (srst_reg && !wr_ccr1 |=> !run_reg && !second_event_flag_reg
                                 && !second_irq_enable_reg && frc_reg == FRC_RST)
        else $error("soft reset left clock state set");

    soft_keep_a: assert property (srst_reg && !wr_csr |=> $stable(src_sel_reg) && $stable(out_sel_reg))
        else $error("soft reset disturbed source select");

    irq_follow_a: assert property (1'b1 |=> second_irq_req
                                   == ($past(second_event_flag_reg) && $past(second_irq_enable_reg)))
        else $error("second interrupt request does not follow flag and enable");

    sub_out_a: assert property (port_mode_three_reg && out_sel_reg[0] |=> clock_output_oe
                                && clock_output_pin == $past(sub_clk))
        else $error("clock output does not carry the subclock");

    prohib_src_a: assert property (wr_csr && src_prohib |=> src_sel_reg == $past(src_sel_reg))
        else $error("prohibited source code was taken");

    reserved_a: assert property (bus_req.rd && hit(bus_req.addr, ADDR_CSR) |=> !rd_data[7])
        else $error("reserved source bit reads nonzero");

    flag_set_a: assert property (sec_ev |=> second_event_flag_reg
                                 ##1 second_irq_req == $past(second_irq_enable_reg))
        else $error("second event did not set the flag");

    flag_clr_a: assert property (flg_clr && !sec_ev && !soft_rst |=> !second_event_flag_reg)
        else $error("zero write did not clear the flag");

    flag_w1_a: assert property (!second_event_flag_reg && wr_flg && !sec_ev |=> !second_event_flag_reg)
        else $error("write set the flag");

    run_write_a: assert property (wr_ccr1 |=> run_reg
                                  == ($past(bus_req.wdata[BIT_RUN]) && !$past(bus_req.wdata[BIT_SRST])))
        else $error("run bit does not follow the control one write");

    ie_write_a: assert property (wr_ccr2 && !soft_rst |=> second_irq_enable_reg
                                 == $past(bus_req.wdata[BIT_SEC_IE]))
        else $error("interrupt enable does not follow the control two write");

    flag_keep_a: assert property (second_event_flag_reg && wr_flg && bus_req.wdata[BIT_SEC_FLG] && !soft_rst
                                  |=> second_event_flag_reg)
        else $error("writing one cleared the flag");

    frc_step_a: assert property (frc_en && !soft_rst |=> frc_reg == $past(frc_reg) + 8'h01)
        else $error("free-running counter missed a subclock edge");

    idle_quiet_a: assert property (!presc_en |=> !sec_tick)
        else $error("second event while not running in clock mode");

    rd_idle_a: assert property (!bus_req.rd |=> rd_data == 8'h00)
        else $error("read data not zero outside a read");

    irq_level_a: assert property (1'b1 |=> irq == |($past(ev_status_reg) & $past(ev_enable_reg)))
        else $error("interrupt output does not follow status and enable");

    ovf_status_a: assert property (frc_ovf |=> ev_status_reg[EV_FRC_OVF])
        else $error("counter overflow not recorded");

    sec_event_c:  cover property (sec_ev ##1 second_irq_req [*2]);
    flag_clear_c: cover property (second_event_flag_reg && flg_clr ##1 !second_event_flag_reg);
    sub_out_c:    cover property (clock_output_oe && clock_output_pin ##1 !clock_output_pin);
    soft_rst_c:   cover property (srst_reg ##1 !srst_reg ##1 run_reg);
    frc_ovf_c:    cover property (frc_ovf ##1 ev_status_reg[EV_FRC_OVF]);
endmodule
`default_nettype wire

// ### logic/rtcc_pkg.sv
// Package: register map, field layout, reset values and timing of the clock control block
package rtcc_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W         = 24;
    localparam logic [23:0] ADDR_CCR1      = 24'hFFF06C;
    localparam logic [23:0] ADDR_CCR2      = 24'hFFF06D;
    localparam logic [23:0] ADDR_FLG       = 24'hFFF06E;
    localparam logic [23:0] ADDR_CSR       = 24'hFFF06F;
    localparam logic [23:0] ADDR_EV_STAT   = 24'hFFF070;
    localparam logic [23:0] ADDR_EV_CLR    = 24'hFFF071;
    localparam logic [23:0] ADDR_EV_EN     = 24'hFFF072;
    localparam logic [23:0] ADDR_PORT_MODE = 24'hFFF073;
    localparam logic [23:0] ADDR_FRC       = 24'hFFF074;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_RUN       = 7;
    localparam int unsigned BIT_SRST      = 4;
    localparam int unsigned BIT_SEC_IE    = 2;
    localparam int unsigned BIT_SEC_FLG   = 2;
    localparam int unsigned BIT_PORT_MODE = 0;
    localparam int unsigned CSR_OUT_LSB   = 4;
    localparam int unsigned CSR_SRC_LSB   = 0;
    localparam int unsigned EV_SEC        = 0;
    localparam int unsigned EV_FRC_OVF    = 1;
    localparam int unsigned EV_W          = 2;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic            RUN_RST     = 1'h0;
    localparam logic [2:0]      OUT_SEL_RST = 3'h0;
    localparam logic [3:0]      SRC_SEL_RST = 4'h0;
    localparam logic [EV_W-1:0] EV_EN_RST   = 2'h0;
    localparam logic [7:0]      FRC_RST     = 8'h00;
    localparam logic [7:0]      FRC_MAX     = 8'hFF;
    localparam logic [3:0]      SRC_RTC     = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned SEC_PERIOD_S      = 1;
    localparam int unsigned SUB_CLK_HZ        = 32768;
    localparam int unsigned SUB_TICKS_DEFAULT = SEC_PERIOD_S * SUB_CLK_HZ;
    localparam int unsigned OUT_DIV_W         = 5;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } rtcc_bus_s;

    typedef struct packed {
        logic pin;
        logic oe;
    } rtcc_pin_s;

endpackage

// ### logic/rtcc_presc.sv
// One-second prescaler counting subclock ticks
`timescale 1ns/1ps
`default_nettype none
module rtcc_presc #(
    parameter int unsigned TICKS = 32768
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clr,
    input  wire logic en,
    input  wire logic tick,
    output logic      sec_pulse
);
    localparam int unsigned CW = $clog2(TICKS);
    localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          pulse_reg;
    wire           wrap = en && tick && (cnt_reg == LAST);

    assign cnt_next  = clr ? '0 : (wrap ? '0 : ((en && tick) ? cnt_reg + 1'b1 : cnt_reg));
    assign sec_pulse = pulse_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg   <= '0;
            pulse_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            pulse_reg <= wrap && !clr;
        end
    end
endmodule
`default_nettype wire

// ### logic/rtcc_clkout.sv
// Clock output selector driving the clock output pin
`timescale 1ns/1ps
`default_nettype none
module rtcc_clkout
    import rtcc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] sel,
    input  wire logic       sub_level,
    input  wire logic       en,
    output rtcc_pkg::rtcc_pin_s pin
);
    logic [OUT_DIV_W-1:0] div_reg;
    logic                 pin_reg;
    logic                 oe_reg;
    wire  logic           div_level;
    wire  logic           pick;

    // Taps: /4, /8, /16, /32 of the system clock
    assign div_level = div_reg[3'(sel[2:1]) + 3'h1];
    assign pick      = sel[0] ? sub_level : div_level;
    assign pin.pin   = pin_reg;
    assign pin.oe    = oe_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= '0;
            pin_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else begin
            div_reg <= div_reg + 1'b1;
            pin_reg <= en && pick;
            oe_reg  <= en;
        end
    end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench of the clock control and one-second flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rtcc_pkg::*;
    // ------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------
    // Short second so a full event takes eight subclock edges, about 56 cycles
    localparam int unsigned TICKS = 8;
    logic        ref_clk;
    logic        rst_b;
    rtcc_bus_s   bus_req;
    logic [7:0]  rd_data;
    logic        sub_clk;
    logic        clock_output_pin;
    logic        clock_output_oe;
    logic        second_irq_req;
    logic        irq;
    int          num_errors;
    int          checks_done;
    int          cnt;
    logic [31:0] seed;
    logic [7:0]  got;
    logic [7:0]  v;
    logic [7:0]  e;
    logic [3:0]  src;
    logic [7:0]  frc0;
    logic        prev;
    logic [23:0] regs [7];

    rtcc_top #(.SUB_TICKS_PER_SEC(TICKS)) i_rtcc_top (
        .ref_clk          (ref_clk),
        .rst_b            (rst_b),
        .bus_req          (bus_req),
        .rd_data          (rd_data),
        .sub_clk          (sub_clk),
        .clock_output_pin (clock_output_pin),
        .clock_output_oe  (clock_output_oe),
        .second_irq_req   (second_irq_req),
        .irq              (irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Expectation helpers and bus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Prohibited source codes leave the old code in place
    function automatic logic [7:0] exp_csr(input logic [7:0] w, input logic [3:0] old);
        return {1'b0, w[6:4], (w[3:0] > 4'h8) ? old : w[3:0]};
    endfunction

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr    <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [23:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd   <= 1'b0;
        #1;
        got = rd_data;
        chk(name, exp, got);
    endtask

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // Subclock stays still between the edges that a test asks for
    task automatic sub_edges(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            sub_clk <= 1'b1;
            repeat (3) @(posedge ref_clk);
            sub_clk <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #600000;
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        bus_req = '0;
        sub_clk = 1'b0;
        num_errors = 0;
        checks_done = 0;
        seed = 32'h00015466;
        regs = '{ADDR_CCR1, ADDR_CCR2, ADDR_FLG, ADDR_CSR, ADDR_EV_EN, ADDR_PORT_MODE, 24'hFFF080};
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        bus_wr(24'hFFF080, 8'hFF);
        foreach (regs[i]) rd_chk("reset value", regs[i], 8'h00);
        chk("irq outputs", 8'h00, {6'h00, irq, second_irq_req});
        $display("test reset done");

        src = 4'h0;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h09 : (i == 2) ? 8'h88 : seed[7:0];
            e = exp_csr(v, src);
            bus_wr(ADDR_CSR, v);
            rd_chk("source select", ADDR_CSR, e);
            src = e[3:0];
        end
        $display("test source select done");

        bus_wr(ADDR_CSR, 8'h03);
        bus_wr(ADDR_CCR1, 8'h80);
        rd_chk("run bit", ADDR_CCR1, 8'h80);
        @(posedge ref_clk);
        bus_req.addr <= ADDR_FRC;
        bus_req.rd   <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd   <= 1'b0;
        #1;
        frc0 = rd_data;
        sub_edges(3);
        rd_chk("counter running", ADDR_FRC, frc0 + 8'h03);
        bus_wr(ADDR_CCR1, 8'h00);
        sub_edges(2);
        rd_chk("counter stopped", ADDR_FRC, frc0 + 8'h03);
        $display("test free running done");

        bus_wr(ADDR_CSR, 8'h08);
        bus_wr(ADDR_CCR2, 8'h04);
        sub_edges(TICKS);
        rd_chk("flag while stopped", ADDR_FLG, 8'h00);
        bus_wr(ADDR_CCR1, 8'h80);
        sub_edges(TICKS - 1);
        rd_chk("flag one edge early", ADDR_FLG, 8'h00);
        sub_edges(1);
        rd_chk("flag after second", ADDR_FLG, 8'h04);
        chk("second request", 8'h01, {7'h00, second_irq_req});
        bus_wr(ADDR_CCR2, 8'h00);
        settle();
        chk("request disabled", 8'h00, {7'h00, second_irq_req});
        bus_wr(ADDR_CCR2, 8'h04);
        settle();
        chk("request enabled", 8'h01, {7'h00, second_irq_req});
        seed = xs(seed);
        bus_wr(ADDR_FLG, seed[7:0] | 8'h04);
        rd_chk("flag after one write", ADDR_FLG, 8'h04);
        bus_wr(ADDR_FLG, 8'h00);
        rd_chk("flag after zero write", ADDR_FLG, 8'h00);
        settle();
        chk("request after clear", 8'h00, {7'h00, second_irq_req});
        $display("test second flag done");

        rd_chk("event status", ADDR_EV_STAT, 8'h01);
        chk("irq masked", 8'h00, {7'h00, irq});
        bus_wr(ADDR_EV_EN, 8'h01);
        settle();
        chk("irq enabled", 8'h01, {7'h00, irq});
        bus_wr(ADDR_EV_EN, 8'h00);
        settle();
        chk("irq remasked", 8'h00, {7'h00, irq});
        bus_wr(ADDR_EV_EN, 8'h01);
        bus_wr(ADDR_EV_CLR, 8'h01);
        settle();
        chk("irq cleared", 8'h00, {7'h00, irq});
        rd_chk("status cleared", ADDR_EV_STAT, 8'h00);
        $display("test interrupt done");

        sub_edges(TICKS);
        rd_chk("flag before soft reset", ADDR_FLG, 8'h04);
        bus_wr(ADDR_CCR1, 8'h90);
        rd_chk("control one in reset", ADDR_CCR1, 8'h10);
        rd_chk("control two in reset", ADDR_CCR2, 8'h00);
        rd_chk("flag in reset", ADDR_FLG, 8'h00);
        rd_chk("source kept", ADDR_CSR, 8'h08);
        sub_edges(TICKS);
        rd_chk("no second in reset", ADDR_FLG, 8'h00);
        bus_wr(ADDR_CCR1, 8'h80);
        rd_chk("control one released", ADDR_CCR1, 8'h80);
        sub_edges(TICKS);
        rd_chk("second after release", ADDR_FLG, 8'h04);
        $display("test soft reset done");

        bus_wr(ADDR_CSR, 8'h18);
        settle();
        chk("pin idle", 8'h00, {6'h00, clock_output_oe, clock_output_pin});
        bus_wr(ADDR_PORT_MODE, 8'h01);
        sub_clk <= 1'b1;
        settle();
        chk("pin follows subclock high", 8'h03, {6'h00, clock_output_oe, clock_output_pin});
        @(posedge ref_clk);
        sub_clk <= 1'b0;
        settle();
        chk("pin follows subclock low", 8'h02, {6'h00, clock_output_oe, clock_output_pin});
        for (int k = 0; k < 4; k++) begin
            bus_wr(ADDR_CSR, {1'b0, k[1:0], 1'b0, 4'h8});
            settle();
            prev = clock_output_pin;
            cnt = 0;
            repeat (32) begin
                @(posedge ref_clk);
                #1;
                if (clock_output_pin !== prev) cnt++;
                prev = clock_output_pin;
            end
            chk("divided output edges", 8'd16 >> k, cnt[7:0]);
        end
        bus_wr(ADDR_PORT_MODE, 8'h00);
        settle();
        chk("pin released", 8'h00, {6'h00, clock_output_oe, clock_output_pin});
        $display("test clock output done");
        bus_wr(ADDR_CSR, 8'h00);
        bus_wr(ADDR_EV_CLR, 8'h03);
        sub_edges(256);
        rd_chk("overflow status", ADDR_EV_STAT, 8'h02);
        @(posedge ref_clk);
        #1;
        chk("read data idle", 8'h00, rd_data);
        rd_chk("counter wrapped", ADDR_FRC, 8'h00);
        $display("test counter overflow done");
        wrap_up();
    end
endmodule
`default_nettype wire
